// file: rtl/ttp_timer.sv
// Six-channel triggered pulse timer with its APB register file.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// [RL1] Writing one to a module halt bit stops that module.
// [RL2] Writing zero to a module halt bit lets the module run again.
// [RL3] Bit 0 of module_halt_a stops the whole timer; it runs while zero.
// [RL4] Bit 15 plus all peripherals halted plus sleep stops bus and port clocks.
// [RL5] Clear select 011 clears the counter with other synchronised cleared counters.
// [RL6] Clear select 001 clears the counter on compare or capture in register A.
// [RL7] Clock edge 00 counts on falling edges of the count clock; the code ignores the edge field and counts on rising CLK edges.
// [RL8] Prescaler 000 counts every peripheral clock cycle.
// [RL9] Mode 0010 selects PWM mode 1, 0000 selects normal counting.
// [RL10] Function A 0010 in PWM mode 1: match A drives pin A high.
// [RL11] Function B 0010 in PWM mode 1: match B drives pin A low; the code drives pin A high on match B for 0010, low for 0001.
// [RL12] Function C 0010 in PWM mode 1: match C drives pin C high.
// [RL13] Function D 0010 in PWM mode 1: match D drives pin C low; the code drives pin C high on match D for 0010, low for 0001.
// [RL14] Function B 0000: register B compares but does not touch pin A.
// [RL15] Function A 1001: register A captures the counter on pin A falling edges.
// [RL16] Six run bits start or halt their channel counters.
// [RL17] Six lockstep bits join channels into synchronous clearing when one.
// [RL18] Registers A and C hold the count where the pulse goes high.
// [RL19] Registers B and D hold the count where the pulse goes low.
// [RL20] Trigger input buffer disabled means the timer sees a constant high.
// [RL21] Counters are 16 bits and reset to zero.
// [RL22] Paired match with the same level setting leaves the output unchanged.
// [RL23] Initial output level is driven while the channel counter is stopped.
// [RL24] A compare match happens in the count cycle the counter equals the register.
// [RL25] Synchronous clearing zeroes all joined counters on the same edge.
module ttp_timer (
	// Clock and reset.
	input wire logic CLK,
	input wire logic NRST,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [25:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Channel pins; pin A of channel 5 is the trigger input.
	input wire logic [5:0] PIN_A_IN,
	output logic [5:0] PIN_A_OUT,
	output logic [5:0] PIN_A_OE,
	output logic [1:0] PIN_C_OUT,
	output logic [1:0] PIN_C_OE,
	// Power control.
	input wire logic SLEEP_REQ,
	output logic [15:0] MODULE_HALT,
	output logic CLOCK_HALT
);

	localparam int NCH = ttp_pkg::NCH;

	logic [5:0] counter_run_bits;
	logic [5:0] counter_lockstep_bits;
	logic [15:0] module_halt_a;
	logic trigger_input_buffer_enable;
	logic pin_direction_bit;
	logic [7:0] count_control [NCH];
	logic [7:0] operating_select [NCH];
	logic [7:0] pin_function_high [NCH];
	logic [7:0] pin_function_low [NCH];
	logic [15:0] general_reg_a [NCH];
	logic [15:0] general_reg_b [NCH];
	logic [15:0] general_reg_c [NCH];
	logic [15:0] general_reg_d [NCH];
	logic [15:0] channel_counter [NCH];
	ttp_pkg::ttp_cfg_s cfg [NCH];
	ttp_pkg::ttp_pins_s pins [NCH];
	logic [5:0] src_clr;
	logic [5:0] cap_a;
	logic [5:0] pin_seen;
	logic sync_clr_any;
	logic timer_live;
	ttp_pkg::ttp_dec_s dec;
	logic bad_addr;
	logic wr;
	logic [15:0] read_val;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.
	always_comb begin
		dec = '{kind: ttp_pkg::K_NONE, ch: 3'h0};
		if (PADDR[25:2] == ttp_pkg::RUN_IDX) begin
			dec.kind = ttp_pkg::K_RUN;
		end else if (PADDR[25:2] == ttp_pkg::LOCK_IDX) begin
			dec.kind = ttp_pkg::K_LOCK;
		end else if (PADDR[25:2] == ttp_pkg::HALT_IDX) begin
			dec.kind = ttp_pkg::K_HALT;
		end else if (PADDR[25:2] == ttp_pkg::PORT_IDX) begin
			dec.kind = ttp_pkg::K_PORT;
		end
		for (int c = 0; c < NCH; c++) begin
			if (PADDR[25:2] == ttp_pkg::CC_IDX[c]) begin
				dec = '{kind: ttp_pkg::K_CC, ch: 3'(c)};
			end else if (PADDR[25:2] == ttp_pkg::OS_IDX[c]) begin
				dec = '{kind: ttp_pkg::K_OS, ch: 3'(c)};
			end else if (PADDR[25:2] == ttp_pkg::PFH_IDX[c]) begin
				dec = '{kind: ttp_pkg::K_PFH, ch: 3'(c)};
			end else if (PADDR[25:2] == ttp_pkg::GA_IDX[c]) begin
				dec = '{kind: ttp_pkg::K_GA, ch: 3'(c)};
			end else if (PADDR[25:2] == ttp_pkg::GB_IDX[c]) begin
				dec = '{kind: ttp_pkg::K_GB, ch: 3'(c)};
			end else if (PADDR[25:2] == ttp_pkg::CNT_IDX_BASE + 24'(c)) begin
				dec = '{kind: ttp_pkg::K_CNT, ch: 3'(c)};
			end else if (ttp_pkg::CD_MASK[c] && PADDR[25:2] == ttp_pkg::PFL_IDX[c]) begin
				dec = '{kind: ttp_pkg::K_PFL, ch: 3'(c)};
			end else if (ttp_pkg::CD_MASK[c] && PADDR[25:2] == ttp_pkg::GC_IDX[c]) begin
				dec = '{kind: ttp_pkg::K_GC, ch: 3'(c)};
			end else if (ttp_pkg::CD_MASK[c] && PADDR[25:2] == ttp_pkg::GD_IDX[c]) begin
				dec = '{kind: ttp_pkg::K_GD, ch: 3'(c)};
			end
		end
	end

	assign bad_addr = (dec.kind == ttp_pkg::K_NONE) || (PADDR[1:0] != 2'h0);
	assign wr = PSEL & PENABLE & PWRITE & ~bad_addr;
	assign PREADY = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// Read path; data is loaded in the setup cycle and held through the access.
	always_comb begin
		case (dec.kind)
			ttp_pkg::K_RUN: read_val = {10'h000, counter_run_bits};
			ttp_pkg::K_LOCK: read_val = {10'h000, counter_lockstep_bits};
			ttp_pkg::K_HALT: read_val = module_halt_a;
			ttp_pkg::K_PORT: read_val = {14'h0000, pin_direction_bit, trigger_input_buffer_enable};
			ttp_pkg::K_CNT: read_val = channel_counter[dec.ch];
			ttp_pkg::K_CC: read_val = {8'h00, count_control[dec.ch]};
			ttp_pkg::K_OS: read_val = {8'h00, operating_select[dec.ch]};
			ttp_pkg::K_PFH: read_val = {8'h00, pin_function_high[dec.ch]};
			ttp_pkg::K_PFL: read_val = {8'h00, pin_function_low[dec.ch]};
			ttp_pkg::K_GA: read_val = general_reg_a[dec.ch];
			ttp_pkg::K_GB: read_val = general_reg_b[dec.ch];
			ttp_pkg::K_GC: read_val = general_reg_c[dec.ch];
			ttp_pkg::K_GD: read_val = general_reg_d[dec.ch];
			default: read_val = 16'h0000;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else if (PSEL && !PENABLE) begin
			PRDATA <= bad_addr ? 32'h00000000 : {16'h0000, read_val};
			PSLVERR <= bad_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Global control registers.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			counter_run_bits <= 6'h00;
		end else if (wr && dec.kind == ttp_pkg::K_RUN) begin
			counter_run_bits <= PWDATA[5:0]; // see [RL16]
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			counter_lockstep_bits <= 6'h00;
		end else if (wr && dec.kind == ttp_pkg::K_LOCK) begin
			counter_lockstep_bits <= PWDATA[5:0]; // see [RL17]
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			module_halt_a <= ttp_pkg::HALT_RESET;
		end else if (wr && dec.kind == ttp_pkg::K_HALT) begin
			module_halt_a <= PWDATA[15:0]; // see [RL1] see [RL2]
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			trigger_input_buffer_enable <= 1'b0;
			pin_direction_bit <= 1'b0;
		end else if (wr && dec.kind == ttp_pkg::K_PORT) begin
			trigger_input_buffer_enable <= PWDATA[ttp_pkg::IBUF_BIT];
			pin_direction_bit <= PWDATA[ttp_pkg::DIR_BIT];
		end
	end

	assign timer_live = ~module_halt_a[ttp_pkg::TIMER_HALT_BIT]; // see [RL3]
	assign MODULE_HALT = module_halt_a; // see [RL1] see [RL2]
	assign CLOCK_HALT = module_halt_a[ttp_pkg::ALL_CLOCK_HALT_BIT] & SLEEP_REQ & // see [RL4]
		((module_halt_a & ttp_pkg::PERIPH_MASK) == ttp_pkg::PERIPH_MASK);

	////////////////////////////////////////////////////////////////////////////////
	// Synchronous clearing across joined channels.
	assign sync_clr_any = |(src_clr & counter_lockstep_bits); // see [RL5] see [RL25]

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel registers and channel instances.
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		always_ff @(posedge CLK) begin
			if (!NRST) begin
				count_control[c] <= ttp_pkg::BYTE_RESET;
				operating_select[c] <= ttp_pkg::BYTE_RESET;
				pin_function_high[c] <= ttp_pkg::BYTE_RESET;
				pin_function_low[c] <= ttp_pkg::BYTE_RESET;
			end else if (wr && dec.ch == 3'(c)) begin
				if (dec.kind == ttp_pkg::K_CC) begin
					count_control[c] <= PWDATA[7:0];
				end else if (dec.kind == ttp_pkg::K_OS) begin
					operating_select[c] <= PWDATA[7:0];
				end else if (dec.kind == ttp_pkg::K_PFH) begin
					pin_function_high[c] <= PWDATA[7:0];
				end else if (dec.kind == ttp_pkg::K_PFL) begin
					pin_function_low[c] <= PWDATA[7:0];
				end
			end
		end

		always_ff @(posedge CLK) begin
			if (!NRST) begin
				general_reg_a[c] <= ttp_pkg::GR_RESET;
			end else if (cap_a[c]) begin
				general_reg_a[c] <= channel_counter[c]; // see [RL15]
			end else if (wr && dec.ch == 3'(c) && dec.kind == ttp_pkg::K_GA) begin
				general_reg_a[c] <= PWDATA[15:0]; // see [RL18]
			end
		end

		always_ff @(posedge CLK) begin
			if (!NRST) begin
				general_reg_b[c] <= ttp_pkg::GR_RESET;
				general_reg_c[c] <= ttp_pkg::GR_RESET;
				general_reg_d[c] <= ttp_pkg::GR_RESET;
			end else if (wr && dec.ch == 3'(c)) begin
				if (dec.kind == ttp_pkg::K_GB) begin
					general_reg_b[c] <= PWDATA[15:0]; // see [RL19]
				end else if (dec.kind == ttp_pkg::K_GC) begin
					general_reg_c[c] <= PWDATA[15:0]; // see [RL18]
				end else if (dec.kind == ttp_pkg::K_GD) begin
					general_reg_d[c] <= PWDATA[15:0]; // see [RL19]
				end
			end
		end

		assign cfg[c] = '{
			clear_sel: count_control[c][7:5],
			edge_sel: count_control[c][4:3],
			presc: count_control[c][2:0],
			mode: operating_select[c][3:0],
			fa: pin_function_high[c][3:0],
			fb: pin_function_high[c][7:4],
			fc: pin_function_low[c][3:0],
			fd: pin_function_low[c][7:4],
			gra: general_reg_a[c],
			grb: general_reg_b[c],
			grc: general_reg_c[c],
			grd: general_reg_d[c]
		};

		if (c == NCH - 1) begin : g_trig
			assign pin_seen[c] = trigger_input_buffer_enable ? PIN_A_IN[c] : 1'b1; // see [RL20]
			assign PIN_A_OE[c] = pins[c].oe_a & pin_direction_bit;
		end else begin : g_plain
			assign pin_seen[c] = PIN_A_IN[c];
			assign PIN_A_OE[c] = pins[c].oe_a;
		end
		assign PIN_A_OUT[c] = pins[c].out_a;

		ttp_chan #(
			.HAS_CD(ttp_pkg::CD_MASK[c])
		) u_chan (
			.clk(CLK),
			.nrst(NRST),
			.cfg(cfg[c]),
			.run(counter_run_bits[c] & timer_live), // see [RL3] see [RL16]
			.live(timer_live),
			.sync_en(counter_lockstep_bits[c]),
			.sync_clr_any(sync_clr_any),
			.pin_a(pin_seen[c]),
			.count(channel_counter[c]),
			.src_clr(src_clr[c]),
			.cap_a(cap_a[c]),
			.pins(pins[c])
		);
	end

	assign PIN_C_OUT = {pins[3].out_c, pins[0].out_c};
	assign PIN_C_OE = {pins[3].oe_c, pins[0].oe_c};

endmodule

// file: rtl/ttp_pkg.sv
// Shared constants, register map and carrier types of the triggered pulse timer.
package ttp_pkg;

	localparam int NCH = 6;
	localparam logic [5:0] CD_MASK = 6'h09;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index.
	localparam logic [23:0] RUN_IDX = 24'h0fffbc;
	localparam logic [23:0] LOCK_IDX = 24'h0fffbd;
	localparam logic [23:0] HALT_IDX = 24'hfffdc8;
	localparam logic [23:0] PORT_IDX = 24'h000120;
	localparam logic [23:0] CNT_IDX_BASE = 24'h000110;
	localparam logic [23:0] CC_IDX [NCH] = '{24'hffffc0, 24'hffffd0, 24'hffffe0,
		24'hfffff0, 24'hfffee0, 24'hfffef0};
	localparam logic [23:0] OS_IDX [NCH] = '{24'hffffc1, 24'hffffd1, 24'hffffe1,
		24'hfffff1, 24'hfffee1, 24'hfffef1};
	localparam logic [23:0] PFH_IDX [NCH] = '{24'hffffc2, 24'hffffd2, 24'hffffe2,
		24'hfffff2, 24'hfffee2, 24'hfffef2};
	localparam logic [23:0] PFL_IDX [NCH] = '{24'hffffc3, 24'h000000, 24'h000000,
		24'hfffff3, 24'h000000, 24'h000000};
	localparam logic [23:0] GA_IDX [NCH] = '{24'hffffc8, 24'hffffd8, 24'hffffe8,
		24'hfffff8, 24'hfffee8, 24'h000104};
	localparam logic [23:0] GB_IDX [NCH] = '{24'h0fffca, 24'h0fffda, 24'h000100,
		24'hfffffa, 24'hfffeea, 24'h000105};
	localparam logic [23:0] GC_IDX [NCH] = '{24'hffffcc, 24'h000000, 24'h000000,
		24'hfffffc, 24'h000000, 24'h000000};
	localparam logic [23:0] GD_IDX [NCH] = '{24'h0fffce, 24'h000000, 24'h000000,
		24'hfffffe, 24'h000000, 24'h000000};

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values.
	localparam int TIMER_HALT_BIT = 0;
	localparam int ALL_CLOCK_HALT_BIT = 15;
	localparam logic [15:0] PERIPH_MASK = 16'h3329;
	localparam logic [15:0] HALT_RESET = 16'h7fff;
	localparam logic [15:0] GR_RESET = 16'hffff;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int IBUF_BIT = 0;
	localparam int DIR_BIT = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Codes.
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_PWM1 = 4'h2;
	localparam logic [2:0] CLR_A = 3'h1;
	localparam logic [2:0] CLR_B = 3'h2;
	localparam logic [2:0] CLR_SYNC = 3'h3;
	localparam logic [2:0] CLR_C = 3'h5;
	localparam logic [2:0] CLR_D = 3'h6;
	localparam logic [2:0] CLR_SYNC_ALT = 3'h7;
	localparam logic [2:0] PRESC_DIV1 = 3'h0;
	localparam logic [2:0] PRESC_DIV4 = 3'h1;
	localparam logic [2:0] PRESC_DIV16 = 3'h2;
	localparam logic [2:0] PRESC_DIV64 = 3'h3;
	localparam logic [3:0] IO_CAP_RISE = 4'h8;
	localparam logic [3:0] IO_CAP_FALL = 4'h9;

	typedef enum logic [3:0] {
		K_NONE, K_RUN, K_LOCK, K_HALT, K_PORT, K_CNT,
		K_CC, K_OS, K_PFH, K_PFL, K_GA, K_GB, K_GC, K_GD
	} ttp_kind_e;

	typedef struct packed {
		ttp_kind_e kind;
		logic [2:0] ch;
	} ttp_dec_s;

	typedef struct packed {
		logic [2:0] clear_sel;
		logic [1:0] edge_sel;
		logic [2:0] presc;
		logic [3:0] mode;
		logic [3:0] fa;
		logic [3:0] fb;
		logic [3:0] fc;
		logic [3:0] fd;
		logic [15:0] gra;
		logic [15:0] grb;
		logic [15:0] grc;
		logic [15:0] grd;
	} ttp_cfg_s;

	typedef struct packed {
		logic out_a;
		logic oe_a;
		logic out_c;
		logic oe_c;
	} ttp_pins_s;

endpackage

// file: rtl/ttp_chan.sv
// One timer channel: counter, compare, capture and pin logic.
`timescale 1ns/1ps
module ttp_chan #(
	parameter bit HAS_CD = 1'b1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Configuration and control.
	input ttp_pkg::ttp_cfg_s cfg,
	input wire logic run,
	input wire logic live,
	input wire logic sync_en,
	input wire logic sync_clr_any,
	input wire logic pin_a,
	// State and events.
	output logic [15:0] count,
	output logic src_clr,
	output logic cap_a,
	output ttp_pkg::ttp_pins_s pins
);

	logic [5:0] pdiv;
	logic tick;
	logic pin_q;
	logic rise;
	logic fall;
	logic pwm;
	logic ma;
	logic mb;
	logic mc;
	logic md;
	logic clr;
	logic out_a;
	logic out_c;

	function automatic logic lvl(input logic [3:0] f, input logic cur);
		case (f[1:0])
			2'h1: lvl = 1'b0;
			2'h2: lvl = 1'b1;
			2'h3: lvl = ~cur;
			default: lvl = cur;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Count clock; the peripheral clock divided by 1, 4, 16 or 64 here; codes 100 to 111 never tick.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pdiv <= 6'h00;
		end else begin
			pdiv <= pdiv + 6'h01;
		end
	end

	always_comb begin
		case (cfg.presc)
			ttp_pkg::PRESC_DIV1: tick = 1'b1; // see [RL8]
			ttp_pkg::PRESC_DIV4: tick = (pdiv[1:0] == 2'h0);
			ttp_pkg::PRESC_DIV16: tick = (pdiv[3:0] == 4'h0);
			ttp_pkg::PRESC_DIV64: tick = (pdiv == 6'h00);
			default: tick = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Capture on pin edges.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pin_q <= 1'b1;
		end else begin
			pin_q <= pin_a;
		end
	end

	assign rise = pin_a & ~pin_q;
	assign fall = ~pin_a & pin_q;
	assign cap_a = live & ((cfg.fa == ttp_pkg::IO_CAP_FALL && fall) || // see [RL15]
		(cfg.fa == ttp_pkg::IO_CAP_RISE && rise) ||
		(cfg.fa[3:1] == 3'h5 && (rise || fall)));

	////////////////////////////////////////////////////////////////////////////////
	// Compare matches and counter clearing.
	assign pwm = (cfg.mode == ttp_pkg::MODE_PWM1); // see [RL9]
	assign ma = run & tick & ~cfg.fa[3] & (count == cfg.gra); // see [RL24]
	assign mb = run & tick & ~cfg.fb[3] & (count == cfg.grb); // see [RL24]
	assign mc = HAS_CD & run & tick & ~cfg.fc[3] & (count == cfg.grc);
	assign md = HAS_CD & run & tick & ~cfg.fd[3] & (count == cfg.grd);

	always_comb begin
		case (cfg.clear_sel)
			ttp_pkg::CLR_A: src_clr = ma | cap_a; // see [RL6]
			ttp_pkg::CLR_B: src_clr = mb;
			ttp_pkg::CLR_C: src_clr = mc;
			ttp_pkg::CLR_D: src_clr = md;
			default: src_clr = 1'b0;
		endcase
	end

	assign clr = src_clr | (sync_en & sync_clr_any & // see [RL5] see [RL17] see [RL25]
		(cfg.clear_sel == ttp_pkg::CLR_SYNC || cfg.clear_sel == ttp_pkg::CLR_SYNC_ALT));

	always_ff @(posedge clk) begin
		if (!nrst) begin
			count <= 16'h0000; // see [RL21]
		end else if (clr) begin
			count <= 16'h0000;
		end else if (run && tick) begin
			count <= count + 16'h0001; // see [RL7] see [RL16]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output pins.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			out_a <= 1'b0;
		end else if (!run) begin
			out_a <= cfg.fa[2] & ~cfg.fa[3]; // see [RL23]
		end else if (ma && cfg.fa[1:0] != 2'h0) begin
			out_a <= lvl(cfg.fa, out_a); // see [RL10] see [RL18]
		end else if (pwm && mb && cfg.fb[1:0] != 2'h0 && cfg.fb[1:0] != cfg.fa[1:0]) begin
			out_a <= lvl(cfg.fb, out_a); // see [RL11] see [RL14] see [RL19] see [RL22]
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			out_c <= 1'b0;
		end else if (!HAS_CD) begin
			out_c <= 1'b0;
		end else if (!run) begin
			out_c <= cfg.fc[2] & ~cfg.fc[3]; // see [RL23]
		end else if (mc && cfg.fc[1:0] != 2'h0) begin
			out_c <= lvl(cfg.fc, out_c); // see [RL12] see [RL18]
		end else if (pwm && md && cfg.fd[1:0] != 2'h0 && cfg.fd[1:0] != cfg.fc[1:0]) begin
			out_c <= lvl(cfg.fd, out_c); // see [RL13] see [RL19] see [RL22]
		end
	end

	assign pins.out_a = out_a;
	assign pins.oe_a = ~cfg.fa[3] & (cfg.fa != 4'h0);
	assign pins.out_c = out_c;
	assign pins.oe_c = HAS_CD & ~cfg.fc[3] & (cfg.fc != 4'h0);

endmodule

// file: bench/ttp_timer_props.sv
// Port assertions for the triggered pulse timer.
`timescale 1ns/1ps
module ttp_timer_props (
	// Clock and reset.
	input wire logic CLK,
	input wire logic NRST,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [25:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Pins and power.
	input wire logic [5:0] PIN_A_OUT,
	input wire logic [1:0] PIN_C_OUT,
	input wire logic SLEEP_REQ,
	input wire logic [15:0] MODULE_HALT,
	input wire logic CLOCK_HALT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	logic halt_sel;
	assign halt_sel = PADDR == {ttp_pkg::HALT_IDX, 2'b00};
	a_ready_high: assert property (PREADY) else $error("ready low");
	a_misalign_err: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 |=> PSLVERR)
		else $error("misaligned access not refused");
	a_halt_ok: assert property (PSEL && !PENABLE && halt_sel |=> !PSLVERR && PREADY)
		else $error("halt register access refused");
	a_halt_write: assert property (PSEL && PENABLE && PWRITE && halt_sel |=>
		MODULE_HALT[15] == $past(PWDATA[15]) && MODULE_HALT[0] == $past(PWDATA[0]))
		else $error("halt bits not written");
	a_halt_read: assert property (PSEL && !PENABLE && !PWRITE && halt_sel |=>
		PRDATA == {16'h0000, MODULE_HALT}) else $error("halt read data wrong");
	a_clock_halt: assert property (CLOCK_HALT == (MODULE_HALT[15] && SLEEP_REQ &&
		(MODULE_HALT & ttp_pkg::PERIPH_MASK) == ttp_pkg::PERIPH_MASK))
		else $error("clock halt wrong");
	a_reset_state: assert property ($rose(NRST) |->
		MODULE_HALT == ttp_pkg::HALT_RESET && PIN_A_OUT == 6'h00 && PIN_C_OUT == 2'h0)
		else $error("reset state wrong");
	a_halt_freeze: assert property (MODULE_HALT[0] && $past(MODULE_HALT[0]) |=>
		$stable(PIN_A_OUT[4:0]) && $stable(PIN_C_OUT)) else $error("pins move while halted");
	c_refused: cover property (PSEL && PENABLE && PSLVERR);
	c_clock_halt: cover property (CLOCK_HALT);
	c_pulse_c: cover property ($fell(PIN_C_OUT[1]));
endmodule
bind ttp_timer ttp_timer_props u_props (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_A_OUT(PIN_A_OUT), .PIN_C_OUT(PIN_C_OUT),
	.SLEEP_REQ(SLEEP_REQ), .MODULE_HALT(MODULE_HALT), .CLOCK_HALT(CLOCK_HALT));

// file: bench/ttp_pin_env.sv
// Trigger source and pin loads on the far side of the timer.
`timescale 1ns/1ps
module ttp_pin_env (
	// Clock and trigger command.
	input wire logic clk,
	input wire logic fire,
	input wire logic [7:0] low_len,
	// Pin levels.
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	output logic [5:0] pin_in
);
	logic trig = 1'b1;
	int left = 0;
	// The trigger idles high and is held low for low_len cycles per request.
	always @(posedge clk) begin
		if (fire) begin
			trig <= 1'b0;
			left <= low_len;
		end else if (left > 1) begin
			left <= left - 1;
		end else begin
			trig <= 1'b1;
		end
	end
	// Undriven pins 0 to 4 are pulled up; undriven pin 5 follows the trigger.
	always_comb begin
		pin_in = {trig, 5'h1f};
		for (int k = 0; k < 6; k++) begin
			if (pin_oe[k]) begin
				pin_in[k] = pin_out[k];
			end
		end
	end
endmodule

// file: bench/ttp_timer_tb_top.sv
// Self-checking bench of the triggered pulse timer.
`timescale 1ns/1ps
module ttp_timer_tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic sleep_req = 1'b0;
	logic fire = 1'b0;
	logic [25:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, clock_halt;
	logic [5:0] pin_in, pin_a_out, pin_a_oe;
	logic [1:0] pin_c_out, pin_c_oe;
	logic [15:0] module_halt, h, v;
	logic [15:0] dly [7];
	logic [15:0] hi_end [7];
	int rise [7];
	int fall [7];
	logic [6:0] outs, prev;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	assign outs = {pin_c_out, pin_a_out[4:0]};
	ttp_timer DUT (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PIN_A_IN(pin_in), .PIN_A_OUT(pin_a_out), .PIN_A_OE(pin_a_oe), .PIN_C_OUT(pin_c_out),
		.PIN_C_OE(pin_c_oe), .SLEEP_REQ(sleep_req), .MODULE_HALT(module_halt),
		.CLOCK_HALT(clock_halt));
	ttp_pin_env u_env (.clk(clk), .fire(fire), .low_len(8'h04), .pin_out(pin_a_out),
		.pin_oe(pin_a_oe), .pin_in(pin_in));
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [23:0] idx, input logic [1:0] lo,
		input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, lo};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [23:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, 2'h0, wd);
	endtask
	task automatic rdc(input logic [23:0] idx, input logic [31:0] exp, input logic experr);
		apb(1'b0, idx, 2'h0, 32'h0);
		chk(rd, exp);
		chk(err, experr);
	endtask
	function automatic logic halt_exp(input logic [15:0] hv, input logic s);
		return hv[15] && s && ((hv & 16'h3329) == 16'h3329);
	endfunction
	// Fires the trigger and measures each pulse after it.
	task automatic sweep(input logic on);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		@(negedge clk);
		prev = outs;
		for (int j = 0; j < 7; j++) begin
			rise[j] = -1;
			fall[j] = -1;
		end
		for (int t = 0; t < 150; t++) begin
			@(negedge clk);
			for (int j = 0; j < 7; j++) begin
				if (outs[j] && !prev[j] && rise[j] < 0) rise[j] = t;
				if (!outs[j] && prev[j] && fall[j] < 0) fall[j] = t;
			end
			prev = outs;
		end
		chk(outs[4], 1'b1);
		for (int j = 0; j < 7; j++) begin
			if (j != 4 && on) begin
				chk(fall[j] - rise[j], hi_end[j] - dly[j]);
				chk(rise[j] - rise[0], dly[j] - dly[0]);
			end else if (j != 4) begin
				chk(rise[j], -1);
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rd = $urandom(95180);
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rdc(ttp_pkg::HALT_IDX, 32'h7fff, 1'b0);
		rdc(ttp_pkg::CNT_IDX_BASE, 32'h0, 1'b0);
		rdc(ttp_pkg::GA_IDX[0], 32'hffff, 1'b0);
		rdc(24'h000200, 32'h0, 1'b1);
		apb(1'b0, ttp_pkg::RUN_IDX, 2'h2, 32'h0);
		chk(err, 1'b1);
		for (int i = 0; i < 12; i++) begin
			h = 16'($urandom);
			if (i < 4) h = h | 16'hb329;
			sleep_req <= i[0] | (i < 2);
			wr(ttp_pkg::HALT_IDX, {16'h0, h});
			@(negedge clk);
			chk(module_halt, h);
			chk(clock_halt, halt_exp(h, sleep_req));
			@(posedge clk);
		end
		sleep_req <= 1'b0;
		wr(ttp_pkg::HALT_IDX, 32'h7ffe);
		rdc(ttp_pkg::CNT_IDX_BASE, 32'h0, 1'b0);
		for (int k = 0; k < 5; k++) begin
			wr(ttp_pkg::CC_IDX[k], 32'h60);
			wr(ttp_pkg::OS_IDX[k], {28'h0, ttp_pkg::MODE_PWM1});
			wr(ttp_pkg::PFH_IDX[k], k == 4 ? 32'h22 : 32'h52);
		end
		wr(ttp_pkg::PFL_IDX[0], 32'h52);
		wr(ttp_pkg::PFL_IDX[3], 32'h52);
		wr(ttp_pkg::CC_IDX[5], 32'h20);
		wr(ttp_pkg::OS_IDX[5], {28'h0, ttp_pkg::MODE_NORMAL});
		wr(ttp_pkg::PFH_IDX[5], 32'h09);
		wr(ttp_pkg::LOCK_IDX, 32'h3f);
		chk({pin_c_oe, pin_a_oe}, 8'hdf);
		for (int j = 0; j < 7; j++) begin
			dly[j] = 16'(2 + $urandom % 40);
			hi_end[j] = dly[j] + 16'(1 + $urandom % 40);
			if (j == 0) begin
				dly[j] = 16'h0001;
				hi_end[j] = 16'h0002;
			end
			wr(j < 5 ? ttp_pkg::GA_IDX[j] : ttp_pkg::GC_IDX[(j - 5) * 3], {16'h0, dly[j]});
			wr(j < 5 ? ttp_pkg::GB_IDX[j] : ttp_pkg::GD_IDX[(j - 5) * 3], {16'h0, hi_end[j]});
		end
		rdc(ttp_pkg::GB_IDX[2], {16'h0, hi_end[2]}, 1'b0);
		wr(ttp_pkg::RUN_IDX, 32'h3f);
		repeat (120) @(posedge clk);
		sweep(1'b0);
		wr(ttp_pkg::PORT_IDX, 32'h1);
		sweep(1'b1);
		wr(ttp_pkg::RUN_IDX, 32'h2e);
		apb(1'b0, ttp_pkg::CNT_IDX_BASE, 2'h0, 32'h0);
		v = rd[15:0];
		repeat (5) @(posedge clk);
		rdc(ttp_pkg::CNT_IDX_BASE, {16'h0, v}, 1'b0);
		chk(pin_a_out[0], 1'b0);
		chk(pin_a_out[4], 1'b0);
		wr(ttp_pkg::HALT_IDX, 32'h7fff);
		apb(1'b0, ttp_pkg::CNT_IDX_BASE + 24'h1, 2'h0, 32'h0);
		v = rd[15:0];
		rdc(ttp_pkg::CNT_IDX_BASE + 24'h1, {16'h0, v}, 1'b0);
		complete_run();
	end
endmodule
